/* design/bp_cmp_pkg.sv */
// Purpose: Shared constants and carriers for the hardware breakpoint compare unit.
// Assumes: 8-bit register port, 16-bit CPU address and data buses.
// Notes:   Register indices and control bit positions are fixed here only.
package bp_cmp_pkg;

   localparam int REG_AW = 3;
   localparam int BUS_W  = 16;

   // Register indices on the register port.
   localparam logic [REG_AW-1:0] REG_CTRL_ZERO = 3'h0;
   localparam logic [REG_AW-1:0] REG_CTRL_ONE  = 3'h1;
   localparam logic [REG_AW-1:0] REG_ADDR_HIGH = 3'h2;
   localparam logic [REG_AW-1:0] REG_ADDR_LOW  = 3'h3;
   localparam logic [REG_AW-1:0] REG_DATA_HIGH = 3'h4;
   localparam logic [REG_AW-1:0] REG_DATA_LOW  = 3'h5;

   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] CTRL_ZERO_USED = 8'hE3;
   localparam logic [7:0] CTRL_ONE_USED  = 8'h7F;

   // Breakpoint mode select codes.
   typedef enum logic [1:0] {
      MODE_OFF      = 2'b00,
      MODE_SWI_DUAL = 2'b01,
      MODE_BDM_FULL = 2'b10,
      MODE_BDM_DUAL = 2'b11
   } bp_mode_e;

   // Control register zero, bit 7 down to bit 0.
   typedef struct packed {
      logic       bp_mode_select_hi;
      logic       bp_mode_select_lo;
      logic       program_only_break;
      logic [2:0] unused;
      logic       second_bp_range_enable;
      logic       first_bp_range_enable;
   } ctrl_zero_s;

   // Control register one, bit 7 down to bit 0.
   typedef struct packed {
      logic unused;
      logic data_reg_compare_enable;
      logic data_high_mask;
      logic data_low_mask;
      logic second_bp_dir_enable;
      logic second_bp_dir_value;
      logic first_bp_dir_enable;
      logic first_bp_dir_value;
   } ctrl_one_s;

   // One CPU bus cycle as seen by the compare logic.
   typedef struct packed {
      logic             valid;
      logic             read;
      logic             fetch;
      logic [BUS_W-1:0] addr;
      logic [BUS_W-1:0] data;
   } bus_cycle_s;

   // One executed instruction at the head of the queue.
   typedef struct packed {
      logic             valid;
      logic [BUS_W-1:0] addr;
   } exec_s;

endpackage

/* design/hw_breakpoint_compare_unit.sv */
// Purpose: Compares CPU bus cycles with preset address and data values and
//          requests a software interrupt or debug mode entry on a match.
// Assumes: All CPU inputs come from logic on core_clk; por_n is power-on reset.
// Notes:   Compare registers survive nrst and clear only on por_n.
`timescale 1ns/1ns

// What this block does
// - Two mode bits select off, interrupt dual, debug full, debug dual.
// - No breakpoint while background debug mode is active.
// - Only interrupt dual mode raises software interrupt; never data breaks there.
// - Interrupt dual mode: range enables count; direction and masks ignored.
// - Dual modes: data compare enable arms second breakpoint on address bus.
// - Full mode ignores second range enable and second direction controls.
// - Full mode: data compare and masks act only without program-only breaking.
// - Debug dual: program-only, ranges, direction used; masks never; program-only drops direction.
// - Debug entry requested only while debug mode is permitted.
// - Immediate break at next boundary, or tagged break when opcode executes.
// - Program-only: data accesses and unexecuted fetches never break.
// - Program-only bit ignored in interrupt dual mode; always program breaks.
// - Second range enable: upper byte only, or full address with low data.
// - First range enable: upper byte only, or full address with low address.
// - Data compare enable clear keeps data registers out of every compare.
// - Full mode high mask excludes data bits 15:8, else compares them.
// - Full mode low mask excludes data bits 7-0, else compares them.
// - Second direction enable qualifies second match in debug dual only.
// - Address registers meet address bus; data registers data or address bus.
// - Both control registers readable and writable at any time.
// - Direction value 0 matches writes, 1 reads; enable clear means any.
// - Four compare registers clear on power-on reset only.
// - Tagged instruction at queue head raises its mode's break (interrupt or debug entry) instead of executing.
module hw_breakpoint_compare_unit
   import bp_cmp_pkg::*;
#(
   parameter int REG_ADDR_W = REG_AW
) (
   // Clock and resets
   input  wire logic                  core_clk,
   input  wire logic                  nrst,
   input  wire logic                  por_n,
   // Register port
   input  wire logic [REG_ADDR_W-1:0] reg_addr,
   input  wire logic [7:0]            reg_wdata,
   input  wire logic                  reg_write,
   input  wire logic                  reg_read,
   output logic      [7:0]            reg_rdata,
   // CPU bus cycle
   input  wire logic                  cpu_cycle_valid,
   input  wire logic                  cpu_read,
   input  wire logic                  cpu_fetch,
   input  wire logic [BUS_W-1:0]      cpu_addr,
   input  wire logic [BUS_W-1:0]      cpu_data,
   // CPU execution progress
   input  wire logic                  cpu_instr_boundary,
   input  wire logic                  cpu_exec_valid,
   input  wire logic [BUS_W-1:0]      cpu_exec_addr,
   input  wire logic                  cpu_queue_flush,
   // Debug logic status
   input  wire logic                  background_debug_mode,
   input  wire logic                  debug_mode_permit,
   // Break requests
   output logic                       software_interrupt,
   output logic                       debug_entry_request
);

   localparam int NUM_BP = 2;

   initial begin
      if (REG_ADDR_W < REG_AW) begin
         $error("REG_ADDR_W too narrow for the register map");
      end
   end

   ctrl_zero_s  ctrl_zero;
   ctrl_one_s   ctrl_one;
   logic [7:0]  bp_addr_high;
   logic [7:0]  bp_addr_low;
   logic [7:0]  bp_data_high;
   logic [7:0]  bp_data_low;
   bp_mode_e    mode;
   bus_cycle_s  cyc;
   exec_s       exe;

   function automatic logic reg_hit(input logic [REG_ADDR_W-1:0] a,
                                    input logic [REG_AW-1:0]     idx);
      reg_hit = (a == REG_ADDR_W'(idx));
   endfunction

   // An enabled direction compare must agree with the cycle direction.
   function automatic logic dir_ok(input logic en, input logic val, input logic rd);
      dir_ok = !en || (rd == val);
   endfunction

   // Upper byte always compared, low byte only when the range bit is set.
   function automatic logic addr_ok(input logic [BUS_W-1:0] a, input logic [7:0] hi,
                                    input logic [7:0] lo, input logic full);
      addr_ok = (a[15:8] == hi) && (!full || (a[7:0] == lo));
   endfunction

   assign cyc = '{valid: cpu_cycle_valid, read: cpu_read, fetch: cpu_fetch,
                  addr: cpu_addr, data: cpu_data};
   assign exe = '{valid: cpu_exec_valid, addr: cpu_exec_addr};
   assign mode = bp_mode_e'({ctrl_zero.bp_mode_select_hi, ctrl_zero.bp_mode_select_lo});

   // Control registers follow the normal reset.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_zero <= ctrl_zero_s'(REG_RESET);
         ctrl_one  <= ctrl_one_s'(REG_RESET);
      end else if (reg_write) begin
         if (reg_hit(reg_addr, REG_CTRL_ZERO)) begin
            ctrl_zero <= ctrl_zero_s'(reg_wdata & CTRL_ZERO_USED);
         end
         if (reg_hit(reg_addr, REG_CTRL_ONE)) begin
            ctrl_one <= ctrl_one_s'(reg_wdata & CTRL_ONE_USED);
         end
      end
   end

   // Compare registers are kept through normal resets.
   always_ff @(posedge core_clk or negedge por_n) begin
      if (!por_n) begin
         bp_addr_high <= REG_RESET;
         bp_addr_low  <= REG_RESET;
         bp_data_high <= REG_RESET;
         bp_data_low  <= REG_RESET;
      end else if (reg_write) begin
         if (reg_hit(reg_addr, REG_ADDR_HIGH)) begin
            bp_addr_high <= reg_wdata;
         end
         if (reg_hit(reg_addr, REG_ADDR_LOW)) begin
            bp_addr_low <= reg_wdata;
         end
         if (reg_hit(reg_addr, REG_DATA_HIGH)) begin
            bp_data_high <= reg_wdata;
         end
         if (reg_hit(reg_addr, REG_DATA_LOW)) begin
            bp_data_low <= reg_wdata;
         end
      end
   end

   // Read data stands in the cycle after the strobe only.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= REG_RESET;
      end else if (!reg_read) begin
         reg_rdata <= REG_RESET;
      end else begin
         unique case (1'b1)
            reg_hit(reg_addr, REG_CTRL_ZERO): reg_rdata <= ctrl_zero;
            reg_hit(reg_addr, REG_CTRL_ONE):  reg_rdata <= ctrl_one;
            reg_hit(reg_addr, REG_ADDR_HIGH): reg_rdata <= bp_addr_high;
            reg_hit(reg_addr, REG_ADDR_LOW):  reg_rdata <= bp_addr_low;
            reg_hit(reg_addr, REG_DATA_HIGH): reg_rdata <= bp_data_high;
            reg_hit(reg_addr, REG_DATA_LOW):  reg_rdata <= bp_data_low;
            default:                          reg_rdata <= REG_RESET;
         endcase
      end
   end

   // Per-breakpoint match, program-only flag and break kind.
   logic [NUM_BP-1:0] bp_match;
   logic              prog_mode;
   logic              use_swi;

   always_comb begin
      bp_match  = '0;
      prog_mode = ctrl_zero.program_only_break;
      use_swi   = 1'b0;
      unique case (mode)
         MODE_OFF: begin
            bp_match = '0;
         end
         MODE_SWI_DUAL: begin
            prog_mode   = 1'b1;
            use_swi     = 1'b1;
            bp_match[0] = addr_ok(cyc.addr, bp_addr_high, bp_addr_low,
                                  ctrl_zero.first_bp_range_enable);
            bp_match[1] = ctrl_one.data_reg_compare_enable &&
                          addr_ok(cyc.addr, bp_data_high, bp_data_low,
                                  ctrl_zero.second_bp_range_enable);
         end
         MODE_BDM_FULL: begin
            // Second breakpoint controls take no part here.
            bp_match[0] = addr_ok(cyc.addr, bp_addr_high, bp_addr_low,
                                  ctrl_zero.first_bp_range_enable);
            if (!prog_mode) begin
               bp_match[0] = bp_match[0] &&
                             dir_ok(ctrl_one.first_bp_dir_enable,
                                    ctrl_one.first_bp_dir_value, cyc.read);
               if (ctrl_one.data_reg_compare_enable) begin
                  bp_match[0] = bp_match[0] &&
                     (ctrl_one.data_high_mask || cyc.data[15:8] == bp_data_high) &&
                     (ctrl_one.data_low_mask || cyc.data[7:0] == bp_data_low);
               end
            end
         end
         MODE_BDM_DUAL: begin
            bp_match[0] = addr_ok(cyc.addr, bp_addr_high, bp_addr_low,
                                  ctrl_zero.first_bp_range_enable);
            bp_match[1] = ctrl_one.data_reg_compare_enable &&
                          addr_ok(cyc.addr, bp_data_high, bp_data_low,
                                  ctrl_zero.second_bp_range_enable);
            if (!prog_mode) begin
               bp_match[0] = bp_match[0] &&
                             dir_ok(ctrl_one.first_bp_dir_enable,
                                    ctrl_one.first_bp_dir_value, cyc.read);
               bp_match[1] = bp_match[1] &&
                             dir_ok(ctrl_one.second_bp_dir_enable,
                                    ctrl_one.second_bp_dir_value, cyc.read);
            end
         end
      endcase
   end

   // Qualified events for this bus cycle.
   logic              armed;
   logic [NUM_BP-1:0] tag_set;
   logic              imm_hit;

   assign armed   = cyc.valid && !background_debug_mode;
   assign imm_hit = armed && !prog_mode && |bp_match;
   assign tag_set = (armed && prog_mode && cyc.fetch) ? bp_match : '0;

   // Immediate break waits for the next instruction boundary.
   logic imm_pending;
   logic imm_swi;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         imm_pending <= 1'b0;
         imm_swi     <= 1'b0;
      end else if (background_debug_mode) begin
         imm_pending <= 1'b0;
      end else if (imm_hit) begin
         imm_pending <= 1'b1;
         imm_swi     <= use_swi;
      end else if (cpu_instr_boundary) begin
         imm_pending <= 1'b0;
      end
   end

   // Each breakpoint holds one tag that follows the fetched opcode.
   logic [NUM_BP-1:0] tag_valid;
   logic [NUM_BP-1:0] tag_swi;
   logic [BUS_W-1:0]  tag_addr [NUM_BP];
   logic [NUM_BP-1:0] tag_fire;

   for (genvar i = 0; i < NUM_BP; i++) begin : g_tag
      assign tag_fire[i] = tag_valid[i] && exe.valid && !background_debug_mode &&
                           (exe.addr == tag_addr[i]);

      always_ff @(posedge core_clk or negedge nrst) begin
         if (!nrst) begin
            tag_valid[i] <= 1'b0;
            tag_swi[i]   <= 1'b0;
            tag_addr[i]  <= '0;
         end else if (background_debug_mode || cpu_queue_flush) begin
            tag_valid[i] <= 1'b0;
         end else if (tag_set[i]) begin
            tag_valid[i] <= 1'b1;
            tag_swi[i]   <= use_swi;
            tag_addr[i]  <= cyc.addr;
         end else if (tag_fire[i]) begin
            tag_valid[i] <= 1'b0;
         end
      end
   end

   // Break requests are one-cycle registered pulses.
   logic fire_swi;
   logic fire_dbg;

   always_comb begin
      fire_swi = 1'b0;
      fire_dbg = 1'b0;
      if (imm_pending && cpu_instr_boundary && !background_debug_mode) begin
         fire_swi = imm_swi;
         fire_dbg = !imm_swi;
      end
      for (int i = 0; i < NUM_BP; i++) begin
         if (tag_fire[i]) begin
            fire_swi = fire_swi || tag_swi[i];
            fire_dbg = fire_dbg || !tag_swi[i];
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         software_interrupt  <= 1'b0;
         debug_entry_request <= 1'b0;
      end else begin
         software_interrupt  <= fire_swi;
         debug_entry_request <= fire_dbg && debug_mode_permit;
      end
   end

endmodule

/* tb/hw_breakpoint_compare_unit_asserts.sv */
// Purpose: Port assertions for the breakpoint compare unit.
// Assumes: One clock, nrst async active low.
// Notes:   Bound from the testbench top file.
`timescale 1ns/1ns
module hw_breakpoint_compare_unit_asserts
   import bp_cmp_pkg::*;
#(
   parameter int REG_ADDR_W = REG_AW
) (
   // Clock and reset
   input wire logic                  core_clk,
   input wire logic                  nrst,
   // Register port
   input wire logic [REG_ADDR_W-1:0] reg_addr,
   input wire logic [7:0]            reg_wdata,
   input wire logic                  reg_write,
   input wire logic                  reg_read,
   input wire logic [7:0]            reg_rdata,
   // CPU progress and debug status
   input wire logic                  cpu_instr_boundary,
   input wire logic                  cpu_exec_valid,
   input wire logic                  background_debug_mode,
   input wire logic                  debug_mode_permit,
   // Break requests
   input wire logic                  software_interrupt,
   input wire logic                  debug_entry_request
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   AST_BDM_QUIET: assert property (background_debug_mode [*2] |=>
      !software_interrupt && !debug_entry_request) else $error("break in debug mode");
   AST_PERMIT_GATE: assert property (debug_entry_request |-> $past(debug_mode_permit))
      else $error("debug entry without permit");
   AST_SWI_AT_EXEC: assert property (software_interrupt |-> $past(cpu_exec_valid))
      else $error("interrupt not at executed opcode");
   AST_DEBUG_AT_STEP: assert property (debug_entry_request |->
      $past(cpu_instr_boundary) || $past(cpu_exec_valid)) else $error("debug entry off step");
   AST_RDATA_IDLE: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
      else $error("read data outside read answer");
   AST_CTRL0_RW: assert property (reg_write && reg_addr == REG_CTRL_ZERO ##1
      reg_read && reg_addr == REG_CTRL_ZERO |=> reg_rdata == ($past(reg_wdata, 2) &
      CTRL_ZERO_USED)) else $error("control zero readback wrong");
   AST_CTRL1_RW: assert property (reg_write && reg_addr == REG_CTRL_ONE ##1
      reg_read && reg_addr == REG_CTRL_ONE |=> reg_rdata == ($past(reg_wdata, 2) &
      CTRL_ONE_USED)) else $error("control one readback wrong");
   AST_UNMAPPED: assert property (reg_read && reg_addr > 3'h5 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   cover property (software_interrupt);
   cover property (debug_entry_request);
   cover property (reg_write ##1 reg_read);
endmodule

/* tb/cpu_bus_model.sv */
// Purpose: Behavioural CPU bus presenting one bus cycle per request.
// Assumes: Request driven by the bench just after core_clk rises.
// Notes:   Idle bus lines show the inverse of their last value.
`timescale 1ns/1ns
module cpu_bus_model
   import bp_cmp_pkg::*;
(
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             nrst,
   // Request, valid asks for one bus cycle
   input  wire bus_cycle_s       cyc,
   // CPU bus
   output logic                  cpu_cycle_valid,
   output logic                  cpu_read,
   output logic                  cpu_fetch,
   output logic      [BUS_W-1:0] cpu_addr,
   output logic      [BUS_W-1:0] cpu_data
);
   // A released bus must not keep showing a value that could still match.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         {cpu_cycle_valid, cpu_read, cpu_fetch, cpu_addr, cpu_data} <= '0;
      end else if (cyc.valid) begin
         {cpu_cycle_valid, cpu_read, cpu_fetch, cpu_addr, cpu_data} <= cyc;
      end else begin
         cpu_cycle_valid <= 1'h0;
         {cpu_read, cpu_fetch, cpu_addr, cpu_data} <= ~{cpu_read, cpu_fetch, cpu_addr, cpu_data};
      end
   end
endmodule

/* tb/test_hw_breakpoint_compare_unit.sv */
// Purpose: Self-checking bench for the breakpoint compare unit.
// Assumes: Compare registers hold 1234 and 5678 during the break cases.
// Notes:   Drivers queue expected results, a monitor pops and compares.
`timescale 1ns/1ns
module test_hw_breakpoint_compare_unit import bp_cmp_pkg::*;;
   logic              core_clk = 1'h0;
   logic              nrst, por_n, reg_write, reg_read, rd_seen;
   logic [REG_AW-1:0] reg_addr;
   logic [7:0]        reg_wdata, reg_rdata, lfsr_q;
   logic [7:0]        vals [8];
   logic              cpu_cycle_valid, cpu_read, cpu_fetch;
   logic [BUS_W-1:0]  cpu_addr, cpu_data, cpu_exec_addr;
   logic              cpu_instr_boundary, cpu_exec_valid, cpu_queue_flush;
   logic              background_debug_mode, debug_mode_permit;
   logic              software_interrupt, debug_entry_request;
   bus_cycle_s        cyc;
   logic [8:0]        notes [$];
   int                fails, checks;
   hw_breakpoint_compare_unit u_hw_breakpoint_compare_unit (
      .core_clk, .nrst, .por_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
      .cpu_cycle_valid, .cpu_read, .cpu_fetch, .cpu_addr, .cpu_data, .cpu_instr_boundary,
      .cpu_exec_valid, .cpu_exec_addr, .cpu_queue_flush, .background_debug_mode,
      .debug_mode_permit, .software_interrupt, .debug_entry_request);
   cpu_bus_model u_cpu_bus_model (.core_clk, .nrst, .cyc, .cpu_cycle_valid, .cpu_read,
      .cpu_fetch, .cpu_addr, .cpu_data);
   always #5 core_clk = ~core_clk;
   function automatic logic [7:0] lfsr_next(input logic [7:0] x);
      return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction
   task automatic pop_chk(input string what, input logic [7:0] seen);
      logic [8:0] n;
      n = (notes.size() > 0) ? notes.pop_front() : 9'h000;
      checks++;
      if (seen !== n[7:0]) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, n[7:0], seen);
      end
   endtask
   task automatic acc(input logic w, input logic r, input logic [2:0] a, input logic [7:0] d);
      reg_write <= w;
      reg_read  <= r;
      reg_addr  <= a;
      reg_wdata <= d;
      if (r) notes.push_back({1'h1, d});
      @(posedge core_clk);
   endtask
   // Flags f are read, fetch, permit and debug-active; ex is the expected break pair.
   task automatic run(input logic [15:0] c, input logic [3:0] f, input logic [15:0] a,
                      input logic [15:0] d, input logic [1:0] ex);
      acc(1'h1, 1'h0, REG_CTRL_ZERO, c[15:8]);
      acc(1'h1, 1'h0, REG_CTRL_ONE, c[7:0]);
      reg_write             <= 1'h0;
      debug_mode_permit     <= f[1];
      background_debug_mode <= f[0];
      cyc                   <= '{1'h1, f[3], f[2], a, d};
      if (ex != 2'h0) notes.push_back({7'h00, ex});
      @(posedge core_clk);
      cyc.valid <= 1'h0;
      repeat (2) @(posedge core_clk);
      cpu_instr_boundary <= 1'h1;
      cpu_exec_valid     <= 1'h1;
      cpu_exec_addr      <= a;
      @(posedge core_clk);
      {cpu_instr_boundary, cpu_exec_valid, background_debug_mode} <= 3'h0;
      repeat (3) @(posedge core_clk);
      cpu_queue_flush <= 1'h1;
      @(posedge core_clk);
      cpu_queue_flush <= 1'h0;
   endtask
   task automatic give_verdict();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   always @(posedge core_clk) rd_seen <= reg_read;
   always @(negedge core_clk) begin
      if (rd_seen) pop_chk("rdata", reg_rdata);
      if (software_interrupt !== 1'h0 || debug_entry_request !== 1'h0) begin
         pop_chk("break", {6'h00, software_interrupt, debug_entry_request});
      end
   end
   // The whole run needs about 290 cycles, so 4000 means a hang.
   initial begin
      #40000;
      fails++;
      give_verdict();
   end
   initial begin
      {nrst, por_n, reg_write, reg_read, cpu_instr_boundary} = '0;
      {cpu_exec_valid, cpu_queue_flush, background_debug_mode, debug_mode_permit} = '0;
      {reg_addr, reg_wdata, cpu_exec_addr, cyc} = '0;
      fails = 0;
      checks = 0;
      lfsr_q = 8'h43;
      repeat (6) @(posedge core_clk);
      nrst  <= 1'h1;
      por_n <= 1'h1;
      @(posedge core_clk);
      for (int i = 0; i < 8; i++) begin
         lfsr_q  = lfsr_next(lfsr_q);
         vals[i] = (i > 5) ? 8'h00 : (i == 0) ? CTRL_ZERO_USED : (i == 1) ? CTRL_ONE_USED : 8'hFF;
         vals[i] = vals[i] & lfsr_q;
         acc(1'h0, 1'h1, i[2:0], 8'h00);
         acc(1'h1, 1'h0, i[2:0], lfsr_q);
         acc(1'h0, 1'h1, i[2:0], vals[i]);
      end
      acc(1'h0, 1'h0, 3'h0, 8'h00);
      nrst <= 1'h0;
      @(posedge core_clk);
      nrst <= 1'h1;
      @(posedge core_clk);
      for (int i = 0; i < 6; i++) acc(1'h0, 1'h1, i[2:0], (i < 2) ? 8'h00 : vals[i]);
      acc(1'h1, 1'h0, REG_ADDR_HIGH, 8'h12);
      acc(1'h1, 1'h0, REG_ADDR_LOW, 8'h34);
      acc(1'h1, 1'h0, REG_DATA_HIGH, 8'h56);
      acc(1'h1, 1'h0, REG_DATA_LOW, 8'h78);
      run(16'h8100, 4'h2, 16'h1234, 16'h0000, 2'h1);
      run(16'h8100, 4'h2, 16'h1235, 16'h0000, 2'h0);
      run(16'h8000, 4'h2, 16'h12FF, 16'h0000, 2'h1);
      run(16'h8140, 4'h2, 16'h1234, 16'h5678, 2'h1);
      run(16'h8140, 4'h2, 16'h1234, 16'h5679, 2'h0);
      run(16'h8150, 4'h2, 16'h1234, 16'h5600, 2'h1);
      run(16'h8160, 4'h2, 16'h1234, 16'h0078, 2'h1);
      run(16'h8160, 4'h2, 16'h1234, 16'h0079, 2'h0);
      run(16'h8103, 4'h2, 16'h1234, 16'h0000, 2'h0);
      run(16'h8103, 4'hA, 16'h1234, 16'h0000, 2'h1);
      run(16'h830C, 4'h2, 16'h1234, 16'h0000, 2'h1);
      run(16'h8100, 4'h0, 16'h1234, 16'h0000, 2'h0);
      run(16'h8100, 4'h3, 16'h1234, 16'h0000, 2'h0);
      run(16'h0100, 4'h2, 16'h1234, 16'h0000, 2'h0);
      run(16'hA140, 4'hE, 16'h1234, 16'h0000, 2'h1);
      run(16'hA100, 4'hA, 16'h1234, 16'h0000, 2'h0);
      run(16'h4102, 4'hC, 16'h1234, 16'h0000, 2'h2);
      run(16'h4100, 4'h2, 16'h1234, 16'h0000, 2'h0);
      run(16'h6100, 4'hE, 16'h1234, 16'h0000, 2'h2);
      run(16'h4240, 4'hE, 16'h5678, 16'h0000, 2'h2);
      run(16'h4040, 4'hE, 16'h56AA, 16'h0000, 2'h2);
      run(16'h4200, 4'hE, 16'h5678, 16'h0000, 2'h0);
      run(16'hC24C, 4'h2, 16'h5678, 16'h0000, 2'h0);
      run(16'hC24C, 4'hA, 16'h5678, 16'h0000, 2'h1);
      repeat (4) @(posedge core_clk);
      checks++;
      if (notes.size() != 0) begin
         fails++;
         $display("CHECK FAILED notes expected 0 seen %0d", notes.size());
      end
      give_verdict();
   end
endmodule
bind hw_breakpoint_compare_unit hw_breakpoint_compare_unit_asserts #(.REG_ADDR_W(REG_ADDR_W))
   u_hw_breakpoint_compare_unit_asserts (.core_clk, .nrst, .reg_addr, .reg_wdata, .reg_write,
   .reg_read, .reg_rdata, .cpu_instr_boundary, .cpu_exec_valid, .background_debug_mode,
   .debug_mode_permit, .software_interrupt, .debug_entry_request);
